/* rtl/alh_pkg.sv */
// package: constants for the legacy host port
package alh_pkg;

  localparam int unsigned CTRL_W          = 16;
  localparam int unsigned STAT_W          = 16;
  localparam int unsigned LEGACY_RX_COUNT = 2;
  localparam int unsigned LEGACY_TX_COUNT = 1;

  // legacy control bit positions
  localparam int unsigned CB_RX1_RATE     = 0;
  localparam int unsigned CB_LABEL_CMP    = 1;
  localparam int unsigned CB_RX1_LREC     = 2;
  localparam int unsigned CB_RX2_LREC     = 3;
  localparam int unsigned CB_PARITY32     = 4;
  localparam int unsigned CB_SELF_TEST    = 5;
  localparam int unsigned CB_RX1_DEC      = 6;
  localparam int unsigned CB_RX1_SD9      = 7;
  localparam int unsigned CB_RX1_SD10     = 8;
  localparam int unsigned CB_RX2_DEC      = 9;
  localparam int unsigned CB_RX2_SD9      = 10;
  localparam int unsigned CB_RX2_SD10     = 11;
  localparam int unsigned CB_TX_PARITY    = 12;
  localparam int unsigned CB_TX_RATE      = 13;
  localparam int unsigned CB_RX2_RATE     = 14;
  localparam int unsigned CB_RELOAD       = 7;

  localparam logic [15:0] CTRL_RESET      = 16'h0020;
  localparam logic [15:0] CTRL_MASK       = 16'h7FFF;
  localparam logic [15:0] STAT_MASK       = 16'h01FF;

  // default-mode register index (cpu address bits 3:2)
  localparam logic [1:0]  REG_DATA        = 2'h0;
  localparam logic [1:0]  REG_CTRL        = 2'h1;
  localparam logic [1:0]  REG_STAT        = 2'h2;
  localparam logic [1:0]  REG_LABEL       = 2'h3;

  // access latencies in clock cycles
  localparam int unsigned RD_FAST_CYC     = 1;
  localparam int unsigned RD_SLOW_CYC     = 6;
  localparam int unsigned WR_CYC          = 2;

  // bit-rate prescale for a 20 MHz master clock, the fastest allowed setting
  localparam int unsigned CLK_HZ          = 20_000_000;
  localparam int unsigned RATE_HI_BPS     = 100_000;
  localparam int unsigned RATE_LO_BPS     = 12_500;
  localparam int unsigned DIV_HI          = CLK_HZ / RATE_HI_BPS;
  localparam int unsigned DIV_LO          = CLK_HZ / RATE_LO_BPS;

  localparam int unsigned LABEL_DEPTH     = 16;

  typedef enum logic [1:0] {ALH_IDLE, ALH_WAIT, ALH_DONE} alh_state_t;

endpackage : alh_pkg

/* rtl/alh_label_mem.sv */
// label memory with separate read and write pointers
`timescale 1ns/10ps
module alh_label_mem
  import alh_pkg::*;
#(
  parameter int unsigned DEPTH = LABEL_DEPTH
)
(
  input  wire logic       clk_i,
  input  wire logic       arst_n_i,
  input  wire logic       reload_i,
  input  wire logic       wr_i,
  input  wire logic [7:0] wr_data_i,
  input  wire logic       rd_i,
  input  wire logic [7:0] probe_i,
  output logic [7:0]      rd_data_o,
  output logic            hit_o
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [7:0]    mem      [DEPTH];
  logic [DEPTH-1:0] valid;
  logic [DEPTH-1:0] next_valid;
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW-1:0] next_wr_ptr;
  logic [AW-1:0] next_rd_ptr;
  logic [7:0]    next_rd_data;
  logic [DEPTH-1:0] match;

  always_comb
  begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_valid  = valid;
    if (reload_i)
    begin
      // old labels stop matching at once
      next_wr_ptr = '0; // R03
      next_rd_ptr = '0; // R03
      next_valid  = '0; // R03
    end
    else
    begin
      if (wr_i)
      begin
        next_wr_ptr         = wr_ptr + 1'b1; // R23
        next_valid[wr_ptr]  = 1'b1;
      end
      if (rd_i)
        next_rd_ptr = rd_ptr + 1'b1; // R23
    end
    // head of table; shows a fresh write to the head one edge late
    next_rd_data = mem[next_rd_ptr];
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      wr_ptr    <= '0;
      rd_ptr    <= '0;
      valid     <= '0;
      rd_data_o <= 8'h00;
    end
    else
    begin
      wr_ptr    <= next_wr_ptr;
      rd_ptr    <= next_rd_ptr;
      valid     <= next_valid;
      rd_data_o <= next_rd_data;
    end
  end

  genvar g;
  generate
    for (g = 0; g < DEPTH; g++)
    begin : g_ent
      always_ff @(posedge clk_i)
      begin
        if (wr_i && !reload_i && wr_ptr == AW'(g))
          mem[g] <= wr_data_i;
      end
      assign match[g] = valid[g] && (mem[g] == probe_i);
    end
  endgenerate

  assign hit_o = |match;

endmodule : alh_label_mem

/* rtl/alh_rate_gen.sv */
// bit-rate tick generator for one channel
`timescale 1ns/10ps
module alh_rate_gen
  import alh_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic arst_n_i,
  input  wire logic slow_i,
  output logic      tick_o
);
  logic [15:0] cnt;
  logic [15:0] next_cnt;
  logic [15:0] limit;

  // master clock tolerance is assumed tight; no drift correction
  assign limit = slow_i ? 16'(DIV_LO - 1) : 16'(DIV_HI - 1); // R06 R22

  always_comb
  begin
    next_cnt = (cnt >= limit) ? 16'h0000 : cnt + 16'h0001;
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cnt    <= 16'h0000;
      tick_o <= 1'b0;
    end
    else
    begin
      cnt    <= next_cnt;
      tick_o <= (cnt >= limit);
    end
  end

endmodule : alh_rate_gen

/* rtl/alh_legacy_port.sv */
// legacy host port: control/status, label access and cpu handshake
// How it works
// R01 - legacy: two receivers, one transmitter, fixed
// R02 - host keeps label-recognition bit cleared
// R03 - reload bit discards stored labels; the code does so only while bit 6 (receiver 1 decode) is clear
// R04 - control loads from bus while strobe low
// R05 - select high, read low: control out
// R06 - rate bits: 0=100k, 1=12.5k
// R07 - label compare: load/read via strobes
// R08 - bits 2,3 enable recognition per receiver
// R09 - bit 4: 32nd bit data or parity
// R10 - bit 5 low loops transmitter back
// R11 - receiver 1 source/dest match on bit 6
// R12 - receiver 2 source/dest match on bit 9
// R13 - bit 12 selects transmitter parity sense
// R14 - select low, read low: status out
// R15 - status 0..5 receiver fifo flags
// R16 - status 6..8 transmitter fifo flags
// R17 - cpu signals sampled on master clock
// R18 - host drops request after wait drops
// R19 - control/status read data after one cycle
// R20 - data/label read data after six cycles
// R21 - writes complete two cycles after sample
// R22 - bit timing from master clock
// R23 - label memory separate read/write counters
// R24 - wait held until access completes
// R25 - unused register bits read zero
`timescale 1ns/10ps
module alh_legacy_port
  import alh_pkg::*;
(
  input  wire logic                clk_i,
  input  wire logic                arst_n_i,
  // legacy strobes
  input  wire logic                ctrl_load_low_i,
  input  wire logic                register_select_i,
  input  wire logic                read_strobe_low_i,
  input  wire logic                label_load_rx1_low_i,
  input  wire logic                label_load_rx2_low_i,
  input  wire logic                label_read_rx1_low_i,
  input  wire logic                label_read_rx2_low_i,
  input  wire logic [15:0]         data_i,
  output logic      [15:0]         data_o,
  output logic                     data_oe_o,
  // default-mode cpu handshake
  input  wire logic                cpu_ren_i,
  input  wire logic                cpu_wen_i,
  input  wire logic [1:0]          cpu_reg_i,
  input  wire logic [15:0]         cpu_wdata_i,
  output logic      [15:0]         cpu_rdata_o,
  output logic                     cpu_wait_o,
  // fifo flags from the channels
  input  wire logic [1:0]          rx_empty_i,
  input  wire logic [1:0]          rx_half_i,
  input  wire logic [1:0]          rx_full_i,
  input  wire logic                tx_empty_i,
  input  wire logic                tx_half_i,
  input  wire logic                tx_full_i,
  input  wire logic [31:0]         rx_data_i,
  // word checks for the receivers
  input  wire logic [1:0]          rx_word_valid_i,
  input  wire logic [31:0]         rx1_word_i,
  input  wire logic [31:0]         rx2_word_i,
  output logic      [1:0]          rx_accept_o,
  // channel controls
  output logic      [1:0]          rx_rate_tick_o,
  output logic                     tx_rate_tick_o,
  output logic                     parity32_o,
  output logic                     tx_even_parity_o,
  output logic                     loopback_o
);

  ////////////////////////////////////////////////////////////////////////////
  // control and status

  logic [15:0] ctrl;
  logic [15:0] next_ctrl;
  logic [15:0] status;
  logic        wr_commit;
  logic [1:0]  wr_reg;
  logic [15:0] wr_data;
  logic [7:0]  lbl_rdata;

  // fixed channel count; nothing here can widen it
  localparam int unsigned RXN = LEGACY_RX_COUNT; // R01

  always_comb
  begin
    next_ctrl = ctrl;
    if (!ctrl_load_low_i)
      next_ctrl = data_i & CTRL_MASK; // R04 R25
    else if (wr_commit && wr_reg == REG_CTRL)
      next_ctrl = wr_data & CTRL_MASK; // R21
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      ctrl <= CTRL_RESET;
    else
      ctrl <= next_ctrl;
  end

  assign status = {7'h00,
                   tx_half_i, tx_full_i, tx_empty_i,                // R16
                   rx_full_i[1], rx_half_i[1], rx_empty_i[1],       // R15
                   rx_full_i[0], rx_half_i[0], rx_empty_i[0]} & STAT_MASK; // R25

  // register read wins; a label read strobe shows the head of the table
  always_comb
  begin
    data_oe_o = !read_strobe_low_i || !label_read_rx1_low_i || !label_read_rx2_low_i;
    if (!read_strobe_low_i)
      data_o = register_select_i ? ctrl : status; // R05 R14
    else
      data_o = {8'h00, lbl_rdata}; // R07
  end

  ////////////////////////////////////////////////////////////////////////////
  // channel controls

  assign parity32_o       = ctrl[CB_PARITY32];       // R09
  assign tx_even_parity_o = ctrl[CB_TX_PARITY];      // R13
  assign loopback_o       = !ctrl[CB_SELF_TEST];     // R10

  alh_rate_gen u_rx1_rate
  (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .slow_i   (ctrl[CB_RX1_RATE]),
    .tick_o   (rx_rate_tick_o[0])
  );

  alh_rate_gen u_rx2_rate
  (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .slow_i   (ctrl[CB_RX2_RATE]),
    .tick_o   (rx_rate_tick_o[1])
  );

  alh_rate_gen u_tx_rate
  (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .slow_i   (ctrl[CB_TX_RATE]),
    .tick_o   (tx_rate_tick_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // label memory

  logic       lbl_wr;
  logic       lbl_rd;
  logic [7:0] lbl_wdata;
  logic [7:0] probe;
  logic       hit;
  logic       reload;
  logic       lbl_rd_cpu;

  // both label strobes share one table; each receiver probes it
  assign reload    = ctrl[CB_RELOAD] && !ctrl[CB_RX1_DEC]; // R03
  assign lbl_wr    = (ctrl[CB_LABEL_CMP] &&
                      (!label_load_rx1_low_i || !label_load_rx2_low_i)) ||
                     (wr_commit && wr_reg == REG_LABEL); // R07 R21
  assign lbl_wdata = (wr_commit && wr_reg == REG_LABEL) ? wr_data[7:0] : data_i[7:0];
  assign lbl_rd    = (ctrl[CB_LABEL_CMP] &&
                      (!label_read_rx1_low_i || !label_read_rx2_low_i)) || lbl_rd_cpu; // R07
  assign probe     = rx_word_valid_i[1] ? rx2_word_i[7:0] : rx1_word_i[7:0];

  alh_label_mem u_labels
  (
    .clk_i     (clk_i),
    .arst_n_i  (arst_n_i),
    .reload_i  (reload),
    .wr_i      (lbl_wr),
    .wr_data_i (lbl_wdata),
    .rd_i      (lbl_rd),
    .probe_i   (probe),
    .rd_data_o (lbl_rdata),
    .hit_o     (hit)
  );

  ////////////////////////////////////////////////////////////////////////////
  // receive word acceptance

  logic [RXN-1:0] lrec_en;
  logic [RXN-1:0] dec_en;
  logic [1:0]     sd_want [RXN];
  logic [1:0]     sd_got  [RXN];

  assign lrec_en    = {ctrl[CB_RX2_LREC], ctrl[CB_RX1_LREC]}; // R08
  assign dec_en     = {ctrl[CB_RX2_DEC], ctrl[CB_RX1_DEC]};
  assign sd_want[0] = {ctrl[CB_RX1_SD10], ctrl[CB_RX1_SD9]}; // R11
  assign sd_want[1] = {ctrl[CB_RX2_SD10], ctrl[CB_RX2_SD9]}; // R12
  assign sd_got[0]  = rx1_word_i[9:8];
  assign sd_got[1]  = rx2_word_i[9:8];

  // receiver 2 has probe priority when both present a word together
  genvar r;
  generate
    for (r = 0; r < RXN; r++)
    begin : g_rx
      logic lbl_ok;
      assign lbl_ok = !lrec_en[r] || (hit && (r == 1 || !rx_word_valid_i[1])); // R08
      assign rx_accept_o[r] = rx_word_valid_i[r] && lbl_ok &&
                              (!dec_en[r] || sd_got[r] == sd_want[r]); // R11 R12
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // default-mode cpu handshake

  alh_state_t  state;
  alh_state_t  next_state;
  logic [2:0]  cnt;
  logic [2:0]  next_cnt;
  logic        is_wr;
  logic        next_is_wr;
  logic [1:0]  next_wr_reg;
  logic [15:0] next_wr_data;
  logic [15:0] next_rdata;

  // write lands on the last wait edge, two edges after the request is taken
  assign wr_commit = (state == ALH_WAIT) && is_wr && (cnt == 3'd0); // R21

  always_comb
  begin
    next_state   = state;
    next_cnt     = cnt;
    next_is_wr   = is_wr;
    next_wr_reg  = wr_reg;
    next_wr_data = wr_data;
    next_rdata   = cpu_rdata_o;
    lbl_rd_cpu   = 1'b0;
    unique case (state)
      ALH_IDLE:
      begin
        if (cpu_ren_i || cpu_wen_i) // R17
        begin
          next_state   = ALH_WAIT;
          next_is_wr   = cpu_wen_i;
          next_wr_reg  = cpu_reg_i;
          // label head is caught here, as the read pointer moves on at this edge
          next_wr_data = cpu_wen_i ? cpu_wdata_i : {8'h00, lbl_rdata};
          if (cpu_wen_i)
            next_cnt = 3'(WR_CYC - 1); // R21
          else if (cpu_reg_i == REG_CTRL || cpu_reg_i == REG_STAT)
            next_cnt = 3'(RD_FAST_CYC - 1); // R19
          else
            next_cnt = 3'(RD_SLOW_CYC - 1); // R20
          lbl_rd_cpu = cpu_ren_i && !cpu_wen_i && cpu_reg_i == REG_LABEL; // R23
        end
      end
      ALH_WAIT:
      begin
        if (cnt == 3'd0)
          next_state = ALH_DONE; // R24
        else
          next_cnt = cnt - 3'd1;
        if (!is_wr && cnt == 3'd0)
        begin
          unique case (wr_reg)
            REG_CTRL:  next_rdata = ctrl;
            REG_STAT:  next_rdata = status;
            REG_LABEL: next_rdata = wr_data; // R20
            REG_DATA:  next_rdata = rx_data_i[15:0];
          endcase
        end
      end
      ALH_DONE:
      begin
        // host drops its request on this edge; a held request is a new access
        next_state = ALH_IDLE; // R18
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state       <= ALH_IDLE;
      cnt         <= 3'd0;
      is_wr       <= 1'b0;
      wr_reg      <= REG_DATA;
      wr_data     <= 16'h0000;
      cpu_rdata_o <= 16'h0000;
    end
    else
    begin
      state       <= next_state;
      cnt         <= next_cnt;
      is_wr       <= next_is_wr;
      wr_reg      <= next_wr_reg;
      wr_data     <= next_wr_data;
      cpu_rdata_o <= next_rdata;
    end
  end

  assign cpu_wait_o = (state == ALH_WAIT) ||
                      (state == ALH_IDLE && (cpu_ren_i || cpu_wen_i)); // R24

endmodule : alh_legacy_port

/* sim/alh_port_props.sv */
// assertions on the pins of the legacy host port
`timescale 1ns/10ps
module alh_port_props (
  input wire logic        clk_i,
  input wire logic        arst_n_i,
  input wire logic        ctrl_load_low_i,
  input wire logic        register_select_i,
  input wire logic        read_strobe_low_i,
  input wire logic        label_read_rx1_low_i,
  input wire logic        label_read_rx2_low_i,
  input wire logic [15:0] data_i,
  input wire logic [15:0] data_o,
  input wire logic        data_oe_o,
  input wire logic        cpu_ren_i,
  input wire logic        cpu_wen_i,
  input wire logic [1:0]  cpu_reg_i,
  input wire logic [15:0] cpu_rdata_o,
  input wire logic        cpu_wait_o,
  input wire logic [1:0]  rx_empty_i,
  input wire logic [1:0]  rx_half_i,
  input wire logic [1:0]  rx_full_i,
  input wire logic        tx_empty_i,
  input wire logic        tx_half_i,
  input wire logic        tx_full_i,
  input wire logic        parity32_o,
  input wire logic        tx_even_parity_o,
  input wire logic        loopback_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  wire logic [15:0] stat_vec = {7'h00, tx_half_i, tx_full_i, tx_empty_i, rx_full_i[1],
    rx_half_i[1], rx_empty_i[1], rx_full_i[0], rx_half_i[0], rx_empty_i[0]};
  wire logic rd_only = cpu_ren_i && !cpu_wen_i;
  wire logic fast_rd = rd_only && (cpu_reg_i == 2'h1 || cpu_reg_i == 2'h2);
  wire logic slow_rd = rd_only && (cpu_reg_i == 2'h0 || cpu_reg_i == 2'h3);
  ////////////////////////////////////////
  a_oe_strobe: assert property (data_oe_o == (!read_strobe_low_i ||
    !label_read_rx1_low_i || !label_read_rx2_low_i)) else $error("output enable wrong");
  a_status_mux: assert property (!register_select_i && !read_strobe_low_i
    |-> data_o == stat_vec) else $error("status readback wrong");
  // a held load strobe would move the captured word, so one load cycle only
  a_ctrl_echo: assert property (register_select_i && !read_strobe_low_i &&
    $past(ctrl_load_low_i, 2) == 1'b0 && $past(ctrl_load_low_i) == 1'b1
    |-> data_o == ($past(data_i, 2) & 16'h7FFF)) else $error("control readback wrong");
  a_ctrl_bits: assert property (!ctrl_load_low_i |=>
    {parity32_o, tx_even_parity_o, loopback_o} ==
    {$past(data_i[4]), $past(data_i[12]), !$past(data_i[5])}) else $error("control outs wrong");
  a_wait_cause: assert property ($rose(cpu_wait_o) |-> cpu_ren_i || cpu_wen_i)
    else $error("wait without request");
  a_write_len: assert property ($rose(cpu_wait_o) && cpu_wen_i
    |-> cpu_wait_o [*3] ##1 !cpu_wait_o) else $error("write wait length wrong");
  a_fast_len: assert property ($rose(cpu_wait_o) && fast_rd
    |-> cpu_wait_o [*2] ##1 !cpu_wait_o) else $error("fast read wait length wrong");
  a_slow_len: assert property ($rose(cpu_wait_o) && slow_rd
    |-> cpu_wait_o [*7] ##1 !cpu_wait_o) else $error("slow read wait length wrong");
  a_stat_data: assert property ($rose(cpu_wait_o) && fast_rd && cpu_reg_i == 2'h2
    |-> ##2 cpu_rdata_o == $past(stat_vec)) else $error("status read data wrong");
  c_write: cover property ($rose(cpu_wait_o) && cpu_wen_i);
  c_slow: cover property ($rose(cpu_wait_o) && slow_rd);
  c_status: cover property (!register_select_i && !read_strobe_low_i);
endmodule : alh_port_props

bind alh_legacy_port alh_port_props u_props (.*);

/* sim/alh_host_model.sv */
// host processor model for the default-mode handshake
`timescale 1ns/10ps
module alh_host_model (
  input  wire logic        clk_i,
  input  wire logic        cpu_wait_i,
  input  wire logic [15:0] cpu_rdata_i,
  output logic             cpu_ren_o,
  output logic             cpu_wen_o,
  output logic [1:0]       cpu_reg_o,
  output logic [15:0]      cpu_wdata_o
);
  initial
  begin
    cpu_ren_o = 1'b0;
    cpu_wen_o = 1'b0;
    cpu_reg_o = 2'h0;
    cpu_wdata_o = 16'h0000;
  end
  ////////////////////////////////////////
  // hi returns the cycles seen with wait high; 20 means it never dropped
  task automatic access(input logic wr, input logic [1:0] idx, input logic [15:0] wd,
                        output logic [15:0] rd, output int hi);
    hi = 0;
    @(posedge clk_i);
    cpu_ren_o <= !wr;
    cpu_wen_o <= wr;
    cpu_reg_o <= idx;
    cpu_wdata_o <= wd;
    for (int i = 0; i < 20; i++)
    begin
      @(negedge clk_i);
      if (cpu_wait_i !== 1'b1)
        break;
      hi++;
    end
    @(posedge clk_i);
    cpu_ren_o <= 1'b0;
    cpu_wen_o <= 1'b0;
    cpu_reg_o <= ~idx;
    cpu_wdata_o <= ~wd;
    @(negedge clk_i);
    rd = cpu_rdata_i;
  endtask : access
endmodule : alh_host_model

/* sim/arinc_legacy_host_port_test.sv */
// self-checking bench for the legacy host port
`timescale 1ns/10ps
module arinc_legacy_host_port_test;
  import alh_pkg::*;
  logic        clk_i, arst_n_i, ctrl_load_low_i, register_select_i, read_strobe_low_i;
  logic        label_load_rx1_low_i, label_load_rx2_low_i, label_read_rx1_low_i;
  logic        label_read_rx2_low_i, cpu_ren_i, cpu_wen_i, tx_empty_i, tx_half_i, tx_full_i;
  logic        data_oe_o, cpu_wait_o, tx_rate_tick_o, parity32_o, tx_even_parity_o, loopback_o;
  logic [1:0]  cpu_reg_i, rx_empty_i, rx_half_i, rx_full_i, rx_word_valid_i, rx_accept_o;
  logic [1:0]  rx_rate_tick_o;
  logic [15:0] data_i, data_o, cpu_wdata_i, cpu_rdata_o, rv;
  logic [31:0] rx_data_i, rx1_word_i, rx2_word_i;
  int          num_errors, compares, hi;

  alh_legacy_port DUT (.*);
  alh_host_model host (.clk_i(clk_i), .cpu_wait_i(cpu_wait_o), .cpu_rdata_i(cpu_rdata_o),
    .cpu_ren_o(cpu_ren_i), .cpu_wen_o(cpu_wen_i), .cpu_reg_o(cpu_reg_i),
    .cpu_wdata_o(cpu_wdata_i));
  ////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic report_and_stop;
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : report_and_stop

  task automatic leg_read(input logic sel, output logic [15:0] v);
    @(posedge clk_i);
    register_select_i <= sel;
    read_strobe_low_i <= 1'b0;
    @(negedge clk_i);
    v = data_o;
    check("oe", 16'(data_oe_o), 16'h0001);
    @(posedge clk_i);
    read_strobe_low_i <= 1'b1;
  endtask : leg_read

  // strobe 0 loads control, strobe 1 loads a label on receiver 1
  task automatic strobe(input logic lab, input logic [15:0] v);
    @(posedge clk_i);
    if (lab)
      label_load_rx1_low_i <= 1'b0;
    else
      ctrl_load_low_i <= 1'b0;
    data_i <= v;
    @(posedge clk_i);
    label_load_rx1_low_i <= 1'b1;
    ctrl_load_low_i <= 1'b1;
    data_i <= ~v;
  endtask : strobe

  task automatic words(input logic [1:0] vld, input logic [31:0] a, input logic [31:0] b);
    @(posedge clk_i);
    rx_word_valid_i <= vld;
    rx1_word_i <= a;
    rx2_word_i <= b;
    @(negedge clk_i);
  endtask : words

  task automatic tick_gap(input int c, output int n);
    logic [2:0] t;
    for (int k = 0; k < 3; k++)
    begin
      n = 0;
      do
      begin
        @(negedge clk_i);
        n++;
        t = {tx_rate_tick_o, rx_rate_tick_o};
      end while (t[c] !== 1'b1 && n < 9000);
      if (n >= 9000)
      begin
        num_errors++;
        report_and_stop();
      end
    end
  endtask : tick_gap
  ////////////////////////////////////////
  task automatic t_legacy;
    leg_read(1'b1, rv);
    check("ctrl reset", rv, CTRL_RESET);
    check("loop reset", 16'(loopback_o), 16'h0000);
    strobe(1'b0, 16'hFFFF);
    leg_read(1'b1, rv);
    check("ctrl", rv, 16'h7FFF);
    check("outs", 16'({parity32_o, tx_even_parity_o, loopback_o}), 16'h0006);
    strobe(1'b0, 16'h0000);
    @(negedge clk_i);
    check("outs", 16'({parity32_o, tx_even_parity_o, loopback_o}), 16'h0001);
  endtask : t_legacy

  task automatic t_status;
    for (int i = 0; i < 9; i++)
    begin
      @(posedge clk_i);
      {tx_half_i, tx_full_i, tx_empty_i, rx_full_i[1], rx_half_i[1], rx_empty_i[1],
        rx_full_i[0], rx_half_i[0], rx_empty_i[0]} <= 9'(1 << i);
      leg_read(1'b0, rv);
      check("status", rv, 16'(1 << i));
    end
    host.access(1'b0, REG_STAT, 16'h0000, rv, hi);
    check("stat cpu", rv, 16'h0100);
    check("stat wait", 16'(hi), 16'h0002);
  endtask : t_status

  task automatic t_cpu;
    host.access(1'b1, REG_CTRL, 16'hFFFF, rv, hi);
    check("wr wait", 16'(hi), 16'h0003);
    leg_read(1'b1, rv);
    check("ctrl cpu", rv, 16'h7FFF);
    host.access(1'b0, REG_CTRL, 16'h0000, rv, hi);
    check("rd ctrl", rv, 16'h7FFF);
    check("rd ctrl wait", 16'(hi), 16'h0002);
    host.access(1'b0, REG_DATA, 16'h0000, rv, hi);
    check("rd data", rv, 16'hABCD);
    check("rd wait", 16'(hi), 16'h0007);
  endtask : t_cpu

  task automatic t_match;
    strobe(1'b0, 16'h0760);
    words(2'h3, 32'h00000200, 32'h00000100);
    check("sdi hit", 16'(rx_accept_o), 16'h0003);
    words(2'h3, 32'h00000100, 32'h00000200);
    check("sdi miss", 16'(rx_accept_o), 16'h0000);
  endtask : t_match

  task automatic t_labels;
    strobe(1'b0, 16'h00A2);
    strobe(1'b0, 16'h0022);
    strobe(1'b1, 16'h005A);
    strobe(1'b1, 16'h00C3);
    host.access(1'b0, REG_LABEL, 16'h0000, rv, hi);
    check("label 0", 16'(rv[7:0]), 16'h005A);
    check("label wait", 16'(hi), 16'h0007);
    host.access(1'b0, REG_LABEL, 16'h0000, rv, hi);
    check("label 1", 16'(rv[7:0]), 16'h00C3);
    check("label wait", 16'(hi), 16'h0007);
    strobe(1'b0, 16'h00A2);
    strobe(1'b0, 16'h0022);
    strobe(1'b1, 16'h003C);
    strobe(1'b0, 16'h0026);
    words(2'h1, 32'h0000005A, 32'h00000000);
    check("old label", 16'(rx_accept_o[0]), 16'h0000);
    words(2'h1, 32'h0000003C, 32'h00000000);
    check("new label", 16'(rx_accept_o[0]), 16'h0001);
    @(posedge clk_i);
    label_read_rx2_low_i <= 1'b0;
    @(negedge clk_i);
    check("label pin", data_o, 16'h003C);
    check("label oe", 16'(data_oe_o), 16'h0001);
    @(posedge clk_i);
    label_read_rx2_low_i <= 1'b1;
    host.access(1'b0, REG_LABEL, 16'h0000, rv, hi);
    check("label next", 16'(rv[7:0]), 16'h00C3);
  endtask : t_labels

  // one rate bit at a time, so a swapped bit shows as a wrong gap
  task automatic t_rates;
    int n;
    int pos [3] = '{CB_RX1_RATE, CB_RX2_RATE, CB_TX_RATE};
    for (int r = 0; r < 2; r++)
      for (int c = 0; c < 3; c++)
      begin
        strobe(1'b0, 16'h0020 | (16'(r) << pos[c]));
        tick_gap(c, n);
        check("tick gap", 16'(n), r ? 16'(DIV_LO) : 16'(DIV_HI));
      end
  endtask : t_rates
  ////////////////////////////////////////
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  initial
  begin
    num_errors = 0;
    compares = 0;
    arst_n_i = 1'b0;
    {ctrl_load_low_i, read_strobe_low_i, label_load_rx1_low_i} = 3'h7;
    {label_load_rx2_low_i, label_read_rx1_low_i, label_read_rx2_low_i} = 3'h7;
    register_select_i = 1'b0;
    data_i = 16'h0000;
    {rx_empty_i, rx_half_i, rx_full_i, tx_empty_i, tx_half_i, tx_full_i} = 9'h000;
    rx_word_valid_i = 2'h0;
    rx_data_i = 32'h1234ABCD;
    rx1_word_i = 32'h00000000;
    rx2_word_i = 32'h00000000;
    repeat (16) @(posedge clk_i);
    arst_n_i <= 1'b1;
    t_legacy();
    t_status();
    t_cpu();
    t_match();
    t_labels();
    t_rates();
    report_and_stop();
  end
endmodule : arinc_legacy_host_port_test
